// [rtl/clkgen_regs_pkg.sv]
// Purpose: Constants for the clock generator configuration/status bank
// Assumes: Registers reached by byte index over the serial config port
// Notes:   Offsets are register indices as printed
package clkgen_regs_pkg;
  localparam logic [3:0] OFS_DEVCFG   = 4'h3;
  localparam logic [3:0] OFS_DIVCFG   = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;
  localparam logic [3:0] OFS_OUTPWR   = 4'h6;
  localparam logic [3:0] OFS_FBPWR    = 4'h7;
  localparam logic [3:0] OFS_MODECFG  = 4'h2;
  localparam int         POS_PIN_GATE = 7;
  localparam int         POS_QUAL     = 6;
  localparam int         POS_SLEW     = 5;
  localparam int         POS_CLR_LO   = 3;
  localparam logic [7:0] RST_DEVCFG   = 8'h00;
  localparam logic [3:0] RST_DIVSEL   = 4'h0;
  localparam logic [7:0] RST_OUTPWR   = 8'h00;
  localparam logic       RST_FBPWR    = 1'b0;
  localparam int         REFAIL_CYC   = 4;
  localparam int         POLL_CYC     = 2;
endpackage

// [rtl/divider_decode.sv]
// Purpose: Map divider select code to input and feedback divider values
// Assumes: Combinational lookup
// Notes:   Reserved codes give zero dividers and a reserved flag
`timescale 1ns/1ps
`default_nettype none
module divider_decode (
  input  wire logic [3:0] sel,
  output logic      [2:0] p_div,
  output logic      [4:0] m_div,
  output logic            reserved
);
  always_comb begin
    reserved = 1'b0;
    unique case (sel)
      4'h0: begin p_div = 3'h1; m_div = 5'h10; end
      4'h1: begin p_div = 3'h1; m_div = 5'h0C; end
      4'h2: begin p_div = 3'h2; m_div = 5'h0C; end
      4'h3: begin p_div = 3'h1; m_div = 5'h08; end
      4'h4: begin p_div = 3'h2; m_div = 5'h10; end
      4'h6: begin p_div = 3'h2; m_div = 5'h08; end
      4'h7: begin p_div = 3'h3; m_div = 5'h0C; end
      4'h8: begin p_div = 3'h4; m_div = 5'h10; end
      4'hA: begin p_div = 3'h4; m_div = 5'h0C; end
      4'hE: begin p_div = 3'h4; m_div = 5'h08; end
      4'hF: begin p_div = 3'h6; m_div = 5'h0C; end
      default: begin p_div = 3'h0; m_div = 5'h00; reserved = 1'b1; end
    endcase
  end
endmodule
`default_nettype wire

// [rtl/clock_gen_config_status_regs.sv]
// Purpose: Configuration and status register bank of the clock generator
// Assumes: Serial port decoded upstream into byte write/read strobes
// Notes:   Status pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module clock_gen_config_status_regs
  import clkgen_regs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] sel_input_pin,
  input  wire logic       lock_pin,
  input  wire logic [3:0] input_fail_pin,
  input  wire logic [3:0] input_valid_qualifiers,
  input  wire logic       external_feedback,
  output logic            int_pin_n,
  output logic      [3:0] ref_qualified,
  output logic            phase_slew_direction,
  output logic      [3:0] bank_output_gate,
  output logic      [2:0] input_divider,
  output logic      [4:0] feedback_divider,
  output logic            divider_reserved,
  output logic      [7:0] output_power_bits,
  output logic            feedback_output_power
);
  logic [7:0] dev_cfg;
  logic [3:0] div_sel;
  logic [7:0] out_pwr;
  logic       fb_pwr;
  logic [1:0] sel_s1, sel_s2, sel_d;
  logic       lock_s1, lock_s2, lock_d;
  logic [3:0] fail_s1, fail_s2;
  logic [3:0] fail_flags;
  logic       int_flag;
  logic [3:0] clear_req;
  logic       status_rd;
  logic       event_hit;
  logic [3:0] qual_s1, qual_s2;
  logic       ext_s1, ext_s2;
  logic       wr_devcfg;
  logic       wr_divcfg;
  logic       wr_outpwr;
  logic       wr_fbpwr;
  logic       wr_modecfg;
  logic [3:0] refail_mask;

  // Cycles allowed for a cleared but still failed flag to come back
  localparam int REFAIL_WIN = REFAIL_CYC;

  // One address compare shared by every write decode and the status read strobe
  function automatic logic addr_hit(input logic [3:0] addr,
                                    input logic [3:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  assign wr_devcfg  = reg_wr && addr_hit(reg_addr, OFS_DEVCFG);
  assign wr_divcfg  = reg_wr && addr_hit(reg_addr, OFS_DIVCFG);
  assign wr_outpwr  = reg_wr && addr_hit(reg_addr, OFS_OUTPWR);
  assign wr_fbpwr   = reg_wr && addr_hit(reg_addr, OFS_FBPWR);
  assign wr_modecfg = reg_wr && addr_hit(reg_addr, OFS_MODECFG);
  assign clear_req  = wr_modecfg ? reg_wdata[POS_CLR_LO +: 4] : 4'h0;
  assign status_rd  = reg_rd && addr_hit(reg_addr, OFS_STATUS);

  // Two-stage synchronisers for the status pins
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sel_s1  <= 2'h0;
      sel_s2  <= 2'h0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      fail_s1 <= 4'h0;
      fail_s2 <= 4'h0;
      qual_s1 <= 4'h0;
      qual_s2 <= 4'h0;
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
    end else begin
      sel_s1  <= sel_input_pin;
      sel_s2  <= sel_s1;
      lock_s1 <= lock_pin;
      lock_s2 <= lock_s1;
      fail_s1 <= input_fail_pin;
      fail_s2 <= fail_s1;
      qual_s1 <= input_valid_qualifiers;
      qual_s2 <= qual_s1;
      ext_s1  <= external_feedback;
      ext_s2  <= ext_s1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sel_d  <= 2'h0;
      lock_d <= 1'b0;
    end else begin
      sel_d  <= sel_s2;
      lock_d <= lock_s2;
    end
  end

  // Device configuration: pin gate, qualifier gate, slew, bank gates
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dev_cfg <= RST_DEVCFG;
    end else if (wr_devcfg) begin
      dev_cfg <= reg_wdata;
    end
  end

  // Divider select; the upper nibble is never stored
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_sel <= RST_DIVSEL;
    end else if (wr_divcfg) begin
      div_sel <= reg_wdata[3:0];
    end
  end

  // Output power bits, one per differential output
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_pwr <= RST_OUTPWR;
    end else if (wr_outpwr) begin
      out_pwr <= reg_wdata;
    end
  end

  // Feedback power bit; bits 7:1 are not stored
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fb_pwr <= RST_FBPWR;
    end else if (wr_fbpwr) begin
      fb_pwr <= reg_wdata[0];
    end
  end

  // Sticky failure flags; a live failure beats a clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fail_flags <= 4'h0;
    end else begin
      fail_flags <= (fail_flags & ~clear_req) | fail_s2;
    end
  end

  // Remembers which cleared flags were still failing, for the refail check
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      refail_mask <= 4'h0;
    end else if (|clear_req) begin
      refail_mask <= clear_req & fail_s2;
    end
  end

  assign event_hit = |(fail_s2 & ~fail_flags)
                   | (lock_d & ~lock_s2)
                   | (sel_d != sel_s2);

  // Interrupt flag: set wins over read clear, independent of pin gate
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      int_flag <= 1'b0;
    end else if (event_hit) begin
      int_flag <= 1'b1;
    end else if (status_rd) begin
      int_flag <= 1'b0;
    end
  end

  always_comb begin
    unique case (reg_addr)
      OFS_DEVCFG:  reg_rdata = dev_cfg;
      OFS_DIVCFG:  reg_rdata = {4'h0, div_sel};
      OFS_STATUS:  reg_rdata = {~int_flag, fail_flags, ~lock_s2, sel_s2};
      OFS_OUTPWR:  reg_rdata = out_pwr;
      OFS_FBPWR:   reg_rdata = {7'h00, fb_pwr};
      default:     reg_rdata = 8'h00;
    endcase
  end

  divider_decode u_div (
    .sel      (div_sel),
    .p_div    (input_divider),
    .m_div    (feedback_divider),
    .reserved (divider_reserved)
  );

  assign int_pin_n = ~(dev_cfg[POS_PIN_GATE] & int_flag);
  assign ref_qualified = dev_cfg[POS_QUAL] ? qual_s2
                                           : 4'hF;
  assign phase_slew_direction = dev_cfg[POS_SLEW];
  assign bank_output_gate = dev_cfg[3:0];
  assign output_power_bits = out_pwr;
  assign feedback_output_power = ext_s2 | fb_pwr;

  // A clear of a still failed input is followed by the flag standing again
  sequence s_clear_failed;
    (clear_req & fail_s2) != 4'h0;
  endsequence

  sequence s_flag_back;
    ##[1:REFAIL_WIN] ((fail_flags & refail_mask) == refail_mask);
  endsequence

  a_refail_bound: assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_clear_failed |-> s_flag_back)
    else $error("Cleared failure flag did not come back");

  // Interrupt flag
  a_int_set: assert property (
    @(posedge core_clk) disable iff (!resetn)
    event_hit |=> int_flag)
    else $error("Interrupt flag missed event");

  a_int_rdclr: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (status_rd && !event_hit) |=> !int_flag)
    else $error("Status read did not clear flag");

  a_int_hold: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (int_flag && !status_rd) |=> int_flag)
    else $error("Interrupt flag fell without a status read");

  a_lock_int: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (lock_d && !lock_s2) |=> int_flag)
    else $error("Lock loss did not raise the flag");

  a_sel_int: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_d != sel_s2) |=> int_flag)
    else $error("Selection change did not raise the flag");

  a_int_ungated: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (event_hit && !dev_cfg[POS_PIN_GATE]) |=> int_flag)
    else $error("Flag not set while pin gate off");

  // Interrupt pin
  a_pin_gate: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !dev_cfg[POS_PIN_GATE] |-> int_pin_n)
    else $error("Interrupt pin active while gated");

  a_pin_follow: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dev_cfg[POS_PIN_GATE] |-> (int_pin_n == !int_flag))
    else $error("Interrupt pin not following flag");

  // Failure flags and status layout
  a_sticky_fail: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ($past(fail_flags) & ~$past(clear_req) & ~fail_flags) == 4'h0)
    else $error("Failure flag dropped without clear");

  a_fail_live: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (fail_flags & $past(fail_s2)) == $past(fail_s2))
    else $error("Live failure not shown in flags");

  a_status_map: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_addr == OFS_STATUS) |-> (reg_rdata[7] == !int_flag
      && reg_rdata[2] == !lock_s2 && reg_rdata[1:0] == sel_s2))
    else $error("Status byte layout wrong");

  // Feedback power
  a_fb_ext: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ext_s2 |-> feedback_output_power)
    else $error("Feedback output off under external feedback");

  a_fb_int: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !ext_s2 |-> (feedback_output_power == fb_pwr))
    else $error("Feedback power not from bit under internal feedback");

  a_fb_upper: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_addr == OFS_FBPWR) |-> (reg_rdata[7:1] == 7'h00))
    else $error("Feedback power upper bits nonzero");

  // Qualifiers
  a_qual_off: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !dev_cfg[POS_QUAL] |-> ref_qualified == 4'hF)
    else $error("Qualifiers not ignored");

  a_qual_on: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dev_cfg[POS_QUAL] |-> ref_qualified == qual_s2)
    else $error("Qualifiers not passed while enabled");

  // Divider and configuration writes
  a_div_upper: assert property (
    @(posedge core_clk) disable iff (!resetn)
    reg_addr == OFS_DIVCFG |-> reg_rdata[7:4] == 4'h0)
    else $error("Divider upper bits nonzero");

  a_div_write: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_divcfg |=> ({4'h0, div_sel} == ($past(reg_wdata) & 8'h0F)))
    else $error("Divider select not written");

  a_div_reserved: assert property (
    @(posedge core_clk) disable iff (!resetn)
    divider_reserved |-> (input_divider == 3'h0 && feedback_divider == 5'h00))
    else $error("Reserved divider code gave nonzero dividers");

  a_cfg_write: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_devcfg |=> (dev_cfg == $past(reg_wdata)))
    else $error("Device configuration not written");

  a_pwr_write: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_outpwr |=> (output_power_bits == $past(reg_wdata)))
    else $error("Output power bits not written");
endmodule
`default_nettype wire

// [verif/reg_host.sv]
// Purpose: Host model issuing register writes and reads
// Assumes: Strobes launched on the falling edge, held over one rising edge
// Notes:   Idles at an unmapped index after each access, with inverted data after a write
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [3:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 4'hF;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_addr  = 4'hF;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk);
    d = reg_rdata;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    reg_addr = 4'hF;
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the clock generator register bank
// Assumes: Status pins settle through the two-stage synchronisers in 6 cycles
// Notes:   Divider table packs P in bits 7:5 and M in bits 4:0
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, resetn, reg_wr, reg_rd, lock_pin, external_feedback;
  logic int_pin_n, phase_slew_direction, divider_reserved, fb_pwr;
  logic [3:0] reg_addr, input_fail_pin, quals, ref_qualified, bank_gate;
  logic [7:0] reg_wdata, reg_rdata, output_power_bits;
  logic [1:0] sel_input_pin;
  logic [2:0] input_divider;
  logic [4:0] feedback_divider;
  int n_mismatch = 0, samples_checked = 0;
  localparam logic [7:0] DIV_TAB [16] = '{8'h30, 8'h2C, 8'h4C, 8'h28,
    8'h50, 8'h00, 8'h48, 8'h6C, 8'h90, 8'h00, 8'h8C, 8'h00, 8'h00, 8'h00,
    8'h88, 8'hCC};
  clock_gen_config_status_regs u_clock_gen_config_status_regs (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sel_input_pin(sel_input_pin),
    .lock_pin(lock_pin), .input_fail_pin(input_fail_pin),
    .input_valid_qualifiers(quals), .external_feedback(external_feedback),
    .int_pin_n(int_pin_n), .ref_qualified(ref_qualified),
    .phase_slew_direction(phase_slew_direction),
    .bank_output_gate(bank_gate), .input_divider(input_divider),
    .feedback_divider(feedback_divider), .divider_reserved(divider_reserved),
    .output_power_bits(output_power_bits), .feedback_output_power(fb_pwr));
  reg_host u_reg_host (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp,
                    input logic [7:0] mask = 8'hFF);
    logic [7:0] d;
    u_reg_host.rd(a, d);
    chk(d & mask, exp);
  endtask
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask
  task automatic t_cfg();
    u_reg_host.wr(4'h3, 8'h65);
    chk({7'h00, phase_slew_direction}, 8'h01);
    chk({4'h0, bank_gate}, 8'h05);
    chk({4'h0, ref_qualified}, 8'h0A);
    u_reg_host.wr(4'h3, 8'h00);
    chk({3'h0, phase_slew_direction, bank_gate}, 8'h00);
    chk({4'h0, ref_qualified}, 8'h0F);
  endtask
  task automatic t_div();
    for (int i = 0; i < 16; i++) begin
      u_reg_host.wr(4'h4, {4'hF, i[3:0]});
      rc(4'h4, {4'h0, i[3:0]});
      chk({input_divider, feedback_divider}, DIV_TAB[i]);
      chk({7'h00, divider_reserved}, {7'h00, DIV_TAB[i] == 8'h00});
    end
  endtask
  task automatic t_pwr();
    u_reg_host.wr(4'h6, 8'hA5);
    rc(4'h6, 8'hA5);
    chk(output_power_bits, 8'hA5);
    u_reg_host.wr(4'h7, 8'hFF);
    rc(4'h7, 8'h01);
    u_reg_host.wr(4'h7, 8'h00);
    chk({7'h00, fb_pwr}, 8'h00);
    external_feedback = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({7'h00, fb_pwr}, 8'h01);
  endtask
  task automatic t_int();
    lock_pin = 1'b1;
    settle();
    rc(4'h5, 8'h80);
    u_reg_host.wr(4'h3, 8'h80);
    chk({7'h00, int_pin_n}, 8'h01);
    input_fail_pin = 4'h4;
    settle();
    chk({7'h00, int_pin_n}, 8'h00);
    rc(4'h5, 8'h20);
    chk({7'h00, int_pin_n}, 8'h01);
    input_fail_pin = 4'h0;
    settle();
    rc(4'h5, 8'hA0);
    u_reg_host.wr(4'h2, 8'h20);
    rc(4'h5, 8'h80);
    input_fail_pin = 4'h1;
    settle();
    rc(4'h5, 8'h08);
    u_reg_host.wr(4'h2, 8'h08);
    repeat (4) @(negedge core_clk);
    rc(4'h5, 8'h08, 8'h78);
    u_reg_host.wr(4'h3, 8'h00);
    input_fail_pin = 4'h0;
    sel_input_pin = 2'h2;
    settle();
    chk({7'h00, int_pin_n}, 8'h01);
    rc(4'h5, 8'h0A);
    lock_pin = 1'b0;
    settle();
    rc(4'h5, 8'h0E);
  endtask
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(50 * 3000);
    n_mismatch++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    lock_pin = 1'b0;
    sel_input_pin = 2'h0;
    input_fail_pin = 4'h0;
    quals = 4'hA;
    external_feedback = 1'b0;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    rc(4'h5, 8'h84);
    rc(4'hF, 8'h00);
    t_cfg();
    t_div();
    t_pwr();
    t_int();
    stop_test();
  end
endmodule
`default_nettype wire
